// ===== hdl/abs_enc_pkg.sv
// Package: constants for the absolute encoder sequencer
package abs_enc_pkg;
  localparam int CLK_HZ = 25000000;
  // Times in milliseconds as printed
  localparam int FAULT_NORMAL_MS = 5000;
  localparam int LOCKOUT_MS = 560;
  localparam int BATT_WINDOW_MS = 4000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  // Longest time fits in 32 bits
  localparam int FAULT_NORMAL_CYC = FAULT_NORMAL_MS * CYC_PER_MS;
  localparam int LOCKOUT_CYC = LOCKOUT_MS * CYC_PER_MS;
  localparam int BATT_WINDOW_CYC = BATT_WINDOW_MS * CYC_PER_MS;
  // Power-up self check length before fault output goes normal
  localparam int SELF_CHECK_CYC = 1000 * CYC_PER_MS;
  // Field values
  localparam logic USAGE_ABSOLUTE = 1'h0;
  localparam logic USAGE_INCREMENTAL = 1'h1;
  localparam logic BATT_LEVEL_ALARM = 1'h0;
  localparam logic BATT_LEVEL_WARNING = 1'h1;
  localparam int CNT_W = 32;
endpackage

// ===== hdl/absolute_encoder_sequencer.sv
// Module: absolute encoder power, lockout and battery sequencing
`timescale 1ns/10ps
//**********************************************************************
//**********************************************************************
module absolute_encoder_sequencer #(
  parameter int FAULT_NORMAL_CYC = abs_enc_pkg::FAULT_NORMAL_CYC,
  parameter int SELF_CHECK_CYC = abs_enc_pkg::SELF_CHECK_CYC,
  parameter int LOCKOUT_CYC = abs_enc_pkg::LOCKOUT_CYC,
  parameter int BATT_WINDOW_CYC = abs_enc_pkg::BATT_WINDOW_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Configuration straps
  input wire logic encoder_usage_select,
  input wire logic battery_fault_level_select,
  // Host commands
  input wire logic encoder_power_on_cmd,
  input wire logic encoder_power_off_cmd,
  input wire logic motor_power_on_cmd,
  input wire logic motor_power_off_cmd,
  // Encoder pins
  input wire logic encoder_power_sense,
  input wire logic battery_low,
  input wire logic position_backup_lost,
  // Status outputs
  output logic fault_output,
  output logic battery_alarm,
  output logic battery_warning,
  output logic encoder_powered,
  output logic motor_powered,
  output logic abs_data_valid,
  output logic position_invalid
);
  //********************************************************************
  // Input synchronisers
  //********************************************************************
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic sense_s;
  logic batt_low_s;
  logic lost_s;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {position_backup_lost, battery_low, encoder_power_sense};
      sync_b <= sync_a;
    end
  end
  assign sense_s = sync_b[0];
  assign batt_low_s = sync_b[1];
  assign lost_s = sync_b[2];

  //********************************************************************
  // Configuration latched at restart
  //********************************************************************
  logic cfg_done;
  logic usage_incr;
  logic level_warn;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_done <= 1'b0;
      usage_incr <= abs_enc_pkg::USAGE_ABSOLUTE;
      level_warn <= abs_enc_pkg::BATT_LEVEL_ALARM;
    end else if (!cfg_done) begin
      cfg_done <= 1'b1;
      usage_incr <= encoder_usage_select;
      level_warn <= battery_fault_level_select;
    end
  end

  //********************************************************************
  // Power-up and fault output
  //********************************************************************
  logic [31:0] up_cnt;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      up_cnt <= 32'h0;
      fault_output <= 1'b0;
    end else if (!fault_output) begin
      up_cnt <= up_cnt + 32'h1;
      if (up_cnt + 32'h1 >= 32'(SELF_CHECK_CYC) || up_cnt + 32'h1 >= 32'(FAULT_NORMAL_CYC)) begin
        fault_output <= 1'b1;
      end
    end
  end

  //********************************************************************
  // Encoder power sequence
  //********************************************************************
  typedef enum logic [1:0] {ENC_OFF, ENC_LOCKOUT, ENC_READY} enc_state_e;
  enc_state_e enc_state;
  logic [31:0] lock_cnt;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enc_state <= ENC_OFF;
      lock_cnt <= 32'h0;
    end else begin
      unique case (enc_state)
        ENC_OFF: begin
          lock_cnt <= 32'h0;
          if (encoder_power_on_cmd && fault_output) begin
            enc_state <= ENC_LOCKOUT;
          end
        end
        ENC_LOCKOUT: begin
          lock_cnt <= lock_cnt + 32'h1;
          if (encoder_power_off_cmd) begin
            enc_state <= ENC_OFF;
          end else if (lock_cnt + 32'h1 >= 32'(LOCKOUT_CYC)) begin
            enc_state <= ENC_READY;
          end
        end
        ENC_READY: begin
          if (encoder_power_off_cmd) begin
            enc_state <= ENC_OFF;
          end
        end
        default: begin
          enc_state <= ENC_OFF;
        end
      endcase
    end
  end
  assign encoder_powered = (enc_state != ENC_OFF);

  //********************************************************************
  // Absolute data
  //********************************************************************
  // Only in absolute use, after sequence, sense present
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      abs_data_valid <= 1'b0;
    end else begin
      abs_data_valid <= (enc_state == ENC_READY) && !usage_incr && sense_s && !position_invalid;
    end
  end

  //********************************************************************
  // Motor power
  //********************************************************************
  // Lockout, alarm or any off command holds motor off
  logic off_request;
  logic motor_block;
  assign off_request = motor_power_off_cmd || encoder_power_off_cmd;
  assign motor_block = off_request || enc_state != ENC_READY || battery_alarm;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      motor_powered <= 1'b0;
    end else if (motor_block) begin
      motor_powered <= 1'b0;
    end else if (motor_power_on_cmd) begin
      motor_powered <= 1'b1;
    end
  end

  //********************************************************************
  // Battery detection
  //********************************************************************
  logic [31:0] win_cnt;
  logic win_open;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      win_cnt <= 32'h0;
      win_open <= 1'b0;
    end else if (fault_output && !level_warn) begin
      if (win_cnt < 32'(BATT_WINDOW_CYC)) begin
        win_cnt <= win_cnt + 32'h1;
        win_open <= 1'b1;
      end else begin
        win_open <= 1'b0;
      end
    end else begin
      win_open <= fault_output && level_warn;
    end
  end

  //********************************************************************
  // Battery indications
  //********************************************************************
  // Alarm sticky until restart, warning follows level
  logic batt_detect;
  assign batt_detect = win_open && !usage_incr && batt_low_s;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      battery_alarm <= 1'b0;
      battery_warning <= 1'b0;
    end else begin
      if (batt_detect && !level_warn) begin
        battery_alarm <= 1'b1;
      end
      battery_warning <= batt_detect && level_warn;
    end
  end

  //********************************************************************
  // Position backup
  //********************************************************************
  // Backup lost flag captured after restart
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      position_invalid <= 1'b0;
    end else if (lost_s && !usage_incr) begin
      position_invalid <= 1'b1;
    end
  end
endmodule // absolute_encoder_sequencer

// ===== testbench/abs_enc_chk_sva.sv
// Checker for the encoder sequencer
`timescale 1ns/10ps
module abs_enc_chk (
  input wire logic sys_clk, rst, encoder_usage_select, battery_fault_level_select, encoder_power_off_cmd,
  input wire logic fault_output, battery_alarm, battery_warning, encoder_powered, motor_powered,
  input wire logic abs_data_valid, position_invalid, motor_power_off_cmd
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence all_off_s;
    !encoder_powered && !motor_powered ##1 !abs_data_valid;
  endsequence
  fault_time_a: assert property ($fell(rst) |-> ##[1:45] fault_output) else $error("fault late");
  lockout_a: assert property ($rose(encoder_powered) |-> !motor_powered [*8]) else $error("motor early");
  abs_cause_a: assert property (abs_data_valid |-> $past(encoder_powered, 8)) else $error("abs early");
  motor_off_a: assert property (motor_power_off_cmd |=> !motor_powered) else $error("motor stays on");
  off_stop_a: assert property (encoder_power_off_cmd && encoder_powered |=> all_off_s) else $error("off");
  alarm_hold_a: assert property (battery_alarm |=> battery_alarm) else $error("alarm dropped");
  level_pick_a: assert property (battery_alarm |-> !battery_fault_level_select) else $error("level");
  warn_pick_a: assert property (battery_warning |-> battery_fault_level_select) else $error("warn");
  incr_quiet_a: assert property (encoder_usage_select |-> !battery_alarm && !abs_data_valid) else $error("inc");
  lost_hold_a: assert property (position_invalid |=> position_invalid) else $error("lost");
endmodule // abs_enc_chk
bind absolute_encoder_sequencer abs_enc_chk abs_enc_chk_inst (.*);

// ===== testbench/host_model.sv
// Host controller model issuing encoder commands
`timescale 1ns/10ps
module host_model (
  input wire logic sys_clk,
  input wire logic fault_output,
  output logic encoder_power_on_cmd,
  output logic encoder_power_off_cmd
);
  initial begin
    encoder_power_on_cmd = 1'h0;
    encoder_power_off_cmd = 1'h0;
  end
  task automatic pulse(input logic off);
    int n;
    n = 0;
    while (fault_output !== 1'h1 && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    if (off) encoder_power_off_cmd = 1'h1;
    else encoder_power_on_cmd = 1'h1;
    @(negedge sys_clk);
    encoder_power_on_cmd = 1'h0;
    encoder_power_off_cmd = 1'h0;
  endtask
endmodule // host_model

// ===== testbench/absolute_encoder_sequencer_test.sv
// Self-checking bench for the encoder sequencer
`timescale 1ns/10ps
module absolute_encoder_sequencer_test;
  logic sys_clk, rst, encoder_usage_select, battery_fault_level_select, encoder_power_on_cmd;
  logic encoder_power_off_cmd, motor_power_on_cmd, motor_power_off_cmd, encoder_power_sense, battery_low;
  logic position_backup_lost, fault_output, battery_alarm, battery_warning, encoder_powered, motor_powered;
  logic abs_data_valid, position_invalid;
  int errors = 0, samples_checked = 0, cycles = 0;
  absolute_encoder_sequencer #(.FAULT_NORMAL_CYC(40), .LOCKOUT_CYC(10),
    .BATT_WINDOW_CYC(30)) absolute_encoder_sequencer_inst (.*);
  host_model host_model_inst (.*);
  initial begin
    sys_clk = 1'h0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      conclude();
    end
  end
  task automatic chk(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic restart(input logic u, input logic l);
    int n;
    n = 0;
    {encoder_usage_select, battery_fault_level_select, battery_low} = {u, l, 1'h0};
    rst = 1'h1;
    cyc(2);
    rst = 1'h0;
    while (fault_output !== 1'h1 && n < 42) begin
      cyc(1);
      n++;
    end
    chk(fault_output, 1'h1);
  endtask
  task automatic t_seq;
    restart(1'h0, 1'h0);
    host_model_inst.pulse(1'h0);
    motor_power_on_cmd = 1'h1;
    cyc(8);
    chk(motor_powered, 1'h0);
    motor_power_on_cmd = 1'h0;
    cyc(6);
    chk(abs_data_valid, 1'h1);
    encoder_power_sense = 1'h0;
    cyc(4);
    chk(abs_data_valid, 1'h0);
    encoder_power_sense = 1'h1;
    cyc(4);
    chk(abs_data_valid, 1'h1);
    motor_power_on_cmd = 1'h1;
    cyc(1);
    motor_power_on_cmd = 1'h0;
    chk(motor_powered, 1'h1);
    motor_power_off_cmd = 1'h1;
    cyc(1);
    motor_power_off_cmd = 1'h0;
    chk(motor_powered, 1'h0);
    motor_power_on_cmd = 1'h1;
    cyc(1);
    motor_power_on_cmd = 1'h0;
    chk(motor_powered, 1'h1);
    host_model_inst.pulse(1'h1);
    chk(encoder_powered, 1'h0);
    chk(motor_powered, 1'h0);
    cyc(1);
    chk(abs_data_valid, 1'h0);
    position_backup_lost = 1'h1;
    cyc(4);
    chk(position_invalid, 1'h1);
    position_backup_lost = 1'h0;
    $display("seq done");
  endtask
  task automatic t_batt(input logic l, input int late, input logic exp);
    restart(1'h0, l);
    cyc(late);
    battery_low = 1'h1;
    cyc(4);
    battery_low = 1'h0;
    cyc(4);
    chk(battery_alarm, exp & ~l);
    chk(battery_warning, 1'h0);
    $display("batt done");
  endtask
  task automatic t_warn;
    restart(1'h0, 1'h1);
    cyc(40);
    battery_low = 1'h1;
    cyc(4);
    chk(battery_warning, 1'h1);
    chk(battery_alarm, 1'h0);
    $display("warn done");
  endtask
  task automatic t_incr;
    restart(1'h1, 1'h0);
    encoder_power_sense = 1'h0;
    battery_low = 1'h1;
    host_model_inst.pulse(1'h0);
    cyc(14);
    chk(encoder_powered, 1'h1);
    chk(abs_data_valid, 1'h0);
    chk(battery_alarm, 1'h0);
    $display("incr done");
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    {rst, encoder_usage_select, battery_fault_level_select, motor_power_on_cmd} = 4'h8;
    {motor_power_off_cmd, battery_low, position_backup_lost, encoder_power_sense} = 4'h1;
    t_seq();
    t_batt(1'h0, 0, 1'h1);
    t_batt(1'h0, 40, 1'h0);
    t_warn();
    t_incr();
    conclude();
  end
endmodule // absolute_encoder_sequencer_test
